// [rtl/oag_top.sv]
// operand effective-address generator: decodes a specifier, updates registers
`timescale 1ns/1ps
// Summary of operation
// - mode 0: register itself is operand
// - mode 1: register holds operand address
// - mode 2: use register, then increment it
// - mode 3: register points to address, increment
// - mode 4: decrement first, then use as address
// - mode 5: decrement, then read address word
// - mode 6: fetch base at pc, add register
// - mode 7: base plus register points to address
// - pc advances two after each fetched word
// - register 7 is pc, accepts all modes
// - code 27: immediate operand after instruction
// - code 37: word at pc is absolute address
// - code 67: offset plus advanced pc
// - code 77: relative address then deferred read
// - modes 6 and 7 take one extra word
// - specifier: mode high bits, register low bits
module oag_top #(
	parameter int DATA_W = oag_pkg::DATA_W
) (
	// clock, reset, enable
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// request from fetch stage
	input wire logic start_i,
	input wire logic [oag_pkg::SPEC_W-1:0] spec_i,
	input wire logic byte_i,
	output logic busy_o,
	// instruction-word fetched notice and register writes from execute
	input wire logic ifetch_i,
	input wire logic wr_en_i,
	input wire logic [oag_pkg::REG_W-1:0] wr_sel_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	// memory read port
	output logic mem_req_o,
	output logic [DATA_W-1:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [DATA_W-1:0] mem_rdata_i,
	// result
	output logic done_o,
	output logic is_reg_o,
	output logic [oag_pkg::REG_W-1:0] opnd_reg_o,
	output logic [DATA_W-1:0] ea_o,
	output logic [DATA_W-1:0] pc_o
);
	oag_pkg::oag_state_type state_q;
	logic [2:0] mode_q;
	logic [2:0] rsel_q;
	logic byte_q;
	logic wait_rd_q;
	logic [DATA_W-1:0] pc_q;
	logic [DATA_W-1:0] base_q;
	logic busy_q;
	logic mem_req_q;
	logic [DATA_W-1:0] mem_addr_q;
	logic done_q;
	logic is_reg_q;
	logic [DATA_W-1:0] ea_q;
	logic [DATA_W-1:0] rd_data;
	logic [DATA_W-1:0] step;
	logic [DATA_W-1:0] regval;
	logic wa_en;
	logic [DATA_W-1:0] wa_data;
	logic [2:0] spec_mode;
	logic [2:0] spec_reg;
	logic [2:0] rd_sel;
	logic take;

	////////////////////////////////////////////////////////////////////////////
	// decode
	assign spec_mode = spec_i[oag_pkg::MODE_MSB:oag_pkg::MODE_LSB];
	assign spec_reg = spec_i[oag_pkg::REG_MSB:oag_pkg::REG_LSB];
	assign take = state_q == oag_pkg::OAG_IDLE && !wait_rd_q && start_i;

	// the register file read is registered, so it is addressed by the incoming
	// specifier on the take edge; the decode cycle then sees that register
	always_comb begin
		if (take) begin
			rd_sel = spec_reg;
		end else begin
			rd_sel = rsel_q;
		end
	end

	// sp and pc stay word aligned, so they never step by one
	always_comb begin
		if (byte_q && rsel_q != oag_pkg::REG_SP && rsel_q != oag_pkg::REG_PC) begin
			step = oag_pkg::STEP_BYTE;
		end else begin
			step = oag_pkg::STEP_WORD;
		end
	end

	// pc lives in its own register, so register 7 reads come from pc_q
	assign regval = (rsel_q == oag_pkg::REG_PC) ? pc_q : rd_data;

	oag_regfile #(
		.DATA_W(DATA_W),
		.NUM_REGS(oag_pkg::NUM_REGS),
		.REG_W(oag_pkg::REG_W)
	) u_regs (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.rd_sel_i(rd_sel),
		.rd_data_o(rd_data),
		.wa_en_i(wa_en),
		.wa_sel_i(rsel_q),
		.wa_data_i(wa_data),
		.wb_en_i(wr_en_i && wr_sel_i != oag_pkg::REG_PC),
		.wb_sel_i(wr_sel_i),
		.wb_data_i(wr_data_i)
	);

	////////////////////////////////////////////////////////////////////////////
	// register side effects on the idle->work step (one cycle after start)
	always_comb begin
		wa_en = 1'b0;
		wa_data = regval;
		if (state_q == oag_pkg::OAG_IDLE && wait_rd_q && rsel_q != oag_pkg::REG_PC) begin
			case (mode_q)
				oag_pkg::MODE_AINC, oag_pkg::MODE_AINC_DEF: begin
					wa_en = 1'b1;
					wa_data = regval + step;
				end
				oag_pkg::MODE_ADEC, oag_pkg::MODE_ADEC_DEF: begin
					wa_en = 1'b1;
					wa_data = regval - step;
				end
				default: begin
					wa_en = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequencer
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			state_q <= oag_pkg::OAG_IDLE;
			mode_q <= oag_pkg::MODE_REG;
			rsel_q <= '0;
			byte_q <= 1'b0;
			wait_rd_q <= 1'b0;
			base_q <= oag_pkg::ADDR_RESET;
			mem_req_q <= 1'b0;
			mem_addr_q <= oag_pkg::ADDR_RESET;
			ea_q <= oag_pkg::ADDR_RESET;
		end else if (ce_i) begin
			case (state_q)
				oag_pkg::OAG_IDLE: begin
					if (wait_rd_q) begin
						wait_rd_q <= 1'b0;
						case (mode_q)
							oag_pkg::MODE_REG: begin
								ea_q <= regval;
								state_q <= oag_pkg::OAG_DONE;
							end
							oag_pkg::MODE_DEF, oag_pkg::MODE_AINC: begin
								ea_q <= regval;
								state_q <= oag_pkg::OAG_DONE;
							end
							oag_pkg::MODE_AINC_DEF: begin
								mem_req_q <= 1'b1;
								mem_addr_q <= regval;
								state_q <= oag_pkg::OAG_READ_PTR;
							end
							oag_pkg::MODE_ADEC: begin
								ea_q <= regval - step;
								state_q <= oag_pkg::OAG_DONE;
							end
							oag_pkg::MODE_ADEC_DEF: begin
								mem_req_q <= 1'b1;
								mem_addr_q <= regval - step;
								state_q <= oag_pkg::OAG_READ_PTR;
							end
							default: begin
								mem_req_q <= 1'b1;
								mem_addr_q <= pc_q;
								base_q <= regval;
								state_q <= oag_pkg::OAG_FETCH_BASE;
							end
						endcase
					end else if (start_i) begin
						mode_q <= spec_mode;
						rsel_q <= spec_reg;
						byte_q <= byte_i;
						wait_rd_q <= 1'b1;
					end
				end
				oag_pkg::OAG_FETCH_BASE: begin
					if (mem_ack_i) begin
						// for register 7 the advanced pc is the base
						if (rsel_q == oag_pkg::REG_PC) begin
							ea_q <= mem_rdata_i + pc_q + oag_pkg::STEP_WORD;
						end else begin
							ea_q <= mem_rdata_i + base_q;
						end
						if (mode_q == oag_pkg::MODE_IDX_DEF) begin
							mem_addr_q <= (rsel_q == oag_pkg::REG_PC) ?
								mem_rdata_i + pc_q + oag_pkg::STEP_WORD :
								mem_rdata_i + base_q;
							state_q <= oag_pkg::OAG_READ_PTR;
						end else begin
							mem_req_q <= 1'b0;
							state_q <= oag_pkg::OAG_DONE;
						end
					end
				end
				oag_pkg::OAG_READ_PTR: begin
					if (mem_ack_i) begin
						mem_req_q <= 1'b0;
						ea_q <= mem_rdata_i;
						state_q <= oag_pkg::OAG_DONE;
					end
				end
				oag_pkg::OAG_DONE: begin
					state_q <= oag_pkg::OAG_IDLE;
				end
				default: begin
					state_q <= oag_pkg::OAG_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// busy: from the take until done_o shows, so start is refused meanwhile
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			busy_q <= 1'b0;
		end else if (ce_i) begin
			if (take) begin
				busy_q <= 1'b1;
			end else if (state_q == oag_pkg::OAG_DONE) begin
				busy_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// done: a one-cycle pulse as the sequencer leaves its last state
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			done_q <= 1'b0;
		end else if (ce_i) begin
			done_q <= (state_q == oag_pkg::OAG_DONE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// operand kind: set on decode, held until the next decode
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			is_reg_q <= 1'b0;
		end else if (ce_i) begin
			if (state_q == oag_pkg::OAG_IDLE && wait_rd_q) begin
				is_reg_q <= (mode_q == oag_pkg::MODE_REG);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// program counter: one concern, all its updates in one place
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			pc_q <= oag_pkg::REG_RESET;
		end else if (ce_i) begin
			if (state_q == oag_pkg::OAG_FETCH_BASE && mem_ack_i) begin
				pc_q <= pc_q + oag_pkg::STEP_WORD;
			end else if (state_q == oag_pkg::OAG_IDLE && wait_rd_q &&
				rsel_q == oag_pkg::REG_PC) begin
				case (mode_q)
					oag_pkg::MODE_AINC, oag_pkg::MODE_AINC_DEF: begin
						pc_q <= pc_q + oag_pkg::STEP_WORD;
					end
					oag_pkg::MODE_ADEC, oag_pkg::MODE_ADEC_DEF: begin
						pc_q <= pc_q - oag_pkg::STEP_WORD;
					end
					default: begin
						pc_q <= pc_q;
					end
				endcase
			end else if (wr_en_i && wr_sel_i == oag_pkg::REG_PC) begin
				pc_q <= wr_data_i;
			end else if (ifetch_i) begin
				pc_q <= pc_q + oag_pkg::STEP_WORD;
			end
		end
	end

	assign busy_o = busy_q;
	assign mem_req_o = mem_req_q;
	assign mem_addr_o = mem_addr_q;
	assign done_o = done_q;
	assign is_reg_o = is_reg_q;
	assign opnd_reg_o = rsel_q;
	assign ea_o = ea_q;
	assign pc_o = pc_q;
endmodule

// [inc/oag_pkg.sv]
// package of constants for the operand address generator
package oag_pkg;
	localparam int DATA_W = 16;
	localparam int SPEC_W = 6;
	localparam int MODE_W = 3;
	localparam int REG_W = 3;
	localparam int NUM_REGS = 8;
	// specifier field positions
	localparam int MODE_MSB = 5;
	localparam int MODE_LSB = 3;
	localparam int REG_MSB = 2;
	localparam int REG_LSB = 0;
	// mode codes
	localparam logic [2:0] MODE_REG = 3'h0;
	localparam logic [2:0] MODE_DEF = 3'h1;
	localparam logic [2:0] MODE_AINC = 3'h2;
	localparam logic [2:0] MODE_AINC_DEF = 3'h3;
	localparam logic [2:0] MODE_ADEC = 3'h4;
	localparam logic [2:0] MODE_ADEC_DEF = 3'h5;
	localparam logic [2:0] MODE_IDX = 3'h6;
	localparam logic [2:0] MODE_IDX_DEF = 3'h7;
	// register numbers with fixed roles
	localparam logic [2:0] REG_SP = 3'h6;
	localparam logic [2:0] REG_PC = 3'h7;
	// step sizes
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	// reset values
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	typedef enum logic [2:0] {
		OAG_IDLE,
		OAG_FETCH_BASE,
		OAG_READ_PTR,
		OAG_DONE
	} oag_state_type;
endpackage

// [rtl/oag_regfile.sv]
// eight general registers with two write ports and registered read
`timescale 1ns/1ps
module oag_regfile #(
	parameter int DATA_W = 16,
	parameter int NUM_REGS = 8,
	parameter int REG_W = 3
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// read port
	input wire logic [REG_W-1:0] rd_sel_i,
	output logic [DATA_W-1:0] rd_data_o,
	// write port a: address generator updates
	input wire logic wa_en_i,
	input wire logic [REG_W-1:0] wa_sel_i,
	input wire logic [DATA_W-1:0] wa_data_i,
	// write port b: external (execute stage), loses to port a on clash
	input wire logic wb_en_i,
	input wire logic [REG_W-1:0] wb_sel_i,
	input wire logic [DATA_W-1:0] wb_data_i
);
	logic [DATA_W-1:0] regs_q [NUM_REGS];
	logic [DATA_W-1:0] rd_data_q;

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_q[i] <= '0;
			end
		end else if (ce_i) begin
			if (wb_en_i) begin
				regs_q[wb_sel_i] <= wb_data_i;
			end
			if (wa_en_i) begin
				regs_q[wa_sel_i] <= wa_data_i;
			end
		end
	end

	// read data comes from a register, so consumers see it one cycle later
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			rd_data_q <= '0;
		end else if (ce_i) begin
			rd_data_q <= regs_q[rd_sel_i];
		end
	end

	assign rd_data_o = rd_data_q;
endmodule

// [testbench/oag_chk.sv]
// port checker for the operand address generator
`timescale 1ns/1ps
module oag_chk #(
	parameter int DATA_W = 16
) (
	// control
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [5:0] spec_i,
	input wire logic busy_o,
	input wire logic ifetch_i,
	input wire logic wr_en_i,
	// memory and result
	input wire logic mem_req_o,
	input wire logic [DATA_W-1:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic done_o,
	input wire logic is_reg_o,
	input wire logic [DATA_W-1:0] ea_o,
	input wire logic [DATA_W-1:0] pc_o
);
	logic tk;
	assign tk = start_i && !busy_o && ce_i;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	////////////////////////////////
	reg_mode_a: assert property (tk && spec_i[5:3] == 3'h0 |-> ##3 done_o && is_reg_o)
		else $error("mode 0 result");
	no_read_a: assert property (tk && (spec_i[5:3] < 3'h3 || spec_i[5:3] == 3'h4)
		|-> ##1 (!mem_req_o) [*3]) else $error("stray read");
	fetch_step_a: assert property (ifetch_i && !busy_o && !start_i && !wr_en_i && ce_i
		|=> pc_o == $past(pc_o) + 16'h0002) else $error("fetch step");
	req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("read dropped");
	pc_word_a: assert property (mem_req_o && mem_ack_i && mem_addr_o == pc_o
		|=> pc_o == $past(pc_o) + 16'h0002) else $error("pc word step");
	imm_code_a: assert property (tk && spec_i == 6'h17 |-> ##3 done_o && ea_o == $past(pc_o, 3)
		&& pc_o == $past(pc_o, 3) + 16'h0002) else $error("immediate");
	pc_dec_a: assert property (tk && spec_i == 6'h27 |-> ##3 done_o
		&& ea_o == $past(pc_o, 3) - 16'h0002) else $error("pc decrement");
	pc_def_a: assert property (tk && spec_i == 6'h0F |-> ##3 done_o && !is_reg_o
		&& ea_o == $past(pc_o, 3)) else $error("pc deferred");
	done_pulse_a: assert property (done_o |=> !done_o) else $error("done width");
endmodule
bind oag_top oag_chk #(.DATA_W(DATA_W)) chk (.clock_i, .rstn_i, .ce_i, .start_i, .spec_i,
	.busy_o, .ifetch_i, .wr_en_i, .mem_req_o, .mem_addr_o, .mem_ack_i, .done_o, .is_reg_o,
	.ea_o, .pc_o);

// [testbench/oag_mem_model.sv]
// memory read partner with settable answer delay
`timescale 1ns/1ps
module oag_mem_model (
	// clock
	input wire logic clock_i,
	// read port
	input wire logic req_i,
	input wire logic [15:0] addr_i,
	input wire logic [3:0] lat_i,
	output logic ack_o,
	output logic [15:0] rdata_o
);
	logic ack_q = 1'b0;
	logic [3:0] cnt_q = 4'h0;
	logic [15:0] d_q = 16'h0000;
	// data only valid with ack; inverse shown otherwise so stale reads show
	assign ack_o = ack_q;
	assign rdata_o = ack_q ? d_q : ~d_q;
	always_ff @(posedge clock_i) begin
		ack_q <= 1'b0;
		if (req_i && !ack_q) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q >= lat_i) begin
				ack_q <= 1'b1;
				d_q <= addr_i + 16'h0100;
				cnt_q <= 4'h0;
			end
		end
	end
endmodule

// [testbench/testbench.sv]
// self-checking bench for the operand address generator
`timescale 1ns/1ps
module testbench;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic start_i = 1'b0, byte_i = 1'b0, ifetch_i = 1'b0, wr_en_i = 1'b0, ce_i = 1'b1;
	logic [5:0] spec_i = 6'h00;
	logic [2:0] wr_sel_i = 3'h0;
	logic [2:0] opnd_reg_o;
	logic [15:0] wr_data_i = 16'h0000;
	logic busy_o, mem_req_o, mem_ack_i, done_o, is_reg_o;
	logic [15:0] mem_addr_o, mem_rdata_i, ea_o, pc_o;
	logic [3:0] lat = 4'h0;
	logic [15:0] r [8] = '{default: 16'h0000};
	int n_mismatch = 0, n_checks = 0;
	always #20 clock_i = ~clock_i;
	oag_top uut (.clock_i, .rstn_i, .ce_i, .start_i, .spec_i, .byte_i, .busy_o, .ifetch_i,
		.wr_en_i, .wr_sel_i, .wr_data_i, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_rdata_i,
		.done_o, .is_reg_o, .opnd_reg_o, .ea_o, .pc_o);
	oag_mem_model mem (.clock_i, .req_i(mem_req_o), .addr_i(mem_addr_o), .lat_i(lat),
		.ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
	////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic cyc;
		@(posedge clock_i);
		#1;
	endtask
	task automatic setr(input logic [2:0] n, input logic [15:0] v);
		wr_en_i = 1'b1;
		wr_sel_i = n;
		wr_data_i = v;
		r[n] = v;
		cyc;
		wr_en_i = 1'b0;
	endtask
	// bench-side reckoning of address and register effects
	task automatic go(input logic [5:0] s, input logic b);
		logic [2:0] m, n;
		logic [15:0] ea, st;
		m = s[5:3];
		n = s[2:0];
		st = (b && n < 3'h6) ? 16'h0001 : 16'h0002;
		if (m == 3'h4 || m == 3'h5)
			r[n] = r[n] - st;
		ea = r[n];
		if (m == 3'h2 || m == 3'h3)
			r[n] = r[n] + st;
		if (m >= 3'h6) begin
			ea = r[7] + 16'h0100;
			r[7] = r[7] + 16'h0002;
			ea = ea + r[n];
		end
		if (m == 3'h3 || m == 3'h5 || m == 3'h7)
			ea = ea + 16'h0100;
		start_i = 1'b1;
		spec_i = s;
		byte_i = b;
		cyc;
		start_i = 1'b0;
		chk({15'h0000, busy_o}, 16'h0001);
		for (int k = 0; k < 40 && done_o !== 1'b1; k++)
			cyc;
		chk(ea_o, ea);
		chk({15'h0000, is_reg_o}, {15'h0000, m == 3'h0});
		chk({13'h0000, opnd_reg_o}, {13'h0000, n});
		chk(pc_o, r[7]);
	endtask
	task automatic t_modes;
		for (int i = 1; i < 7; i++)
			setr(i[2:0], 16'h1000 * i[15:0]);
		for (int m = 0; m < 8; m++)
			go({m[2:0], 3'h2}, 1'b0);
		go(6'h11, 1'b1);
		go(6'h21, 1'b1);
		go(6'h16, 1'b1);
		go(6'h01, 1'b0);
		$display("modes test over");
	endtask
	task automatic t_pc;
		logic [5:0] codes [7] = '{6'h07, 6'h0F, 6'h17, 6'h1F, 6'h27, 6'h37, 6'h3F};
		setr(3'h7, 16'h0020);
		// a frozen clock enable must swallow the fetch notice
		ce_i = 1'b0;
		ifetch_i = 1'b1;
		cyc;
		ifetch_i = 1'b0;
		ce_i = 1'b1;
		chk(pc_o, r[7]);
		ifetch_i = 1'b1;
		cyc;
		ifetch_i = 1'b0;
		r[7] = r[7] + 16'h0002;
		cyc;
		chk(pc_o, r[7]);
		foreach (codes[i])
			go(codes[i], 1'b0);
		$display("pc test over");
	endtask
	task automatic t_slow;
		// slow memory stretches both reads of deferred index
		lat = 4'h3;
		go(6'h3A, 1'b0);
		go(6'h2D, 1'b0);
		lat = 4'h0;
		$display("slow test over");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		#1 rstn_i = 1'b1;
		t_modes;
		t_pc;
		t_slow;
		test_done;
	end
	initial begin
		#50000;
		n_mismatch++;
		test_done;
	end
endmodule
